/* File: design/ata_pkg.sv */
// shared constants and types for both ends of the parallel disk port
// assumes one common 100 MHz clock for host end and device end
package ata_pkg;

  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LVL_W = 4;
  localparam int CNT_W = 12;

  // power-on reset of the link
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_US = 25;
  localparam logic [CNT_W-1:0] RESET_HOLD_CYC =
    CNT_W'((RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // host strobe pacing
  localparam logic [CNT_W-1:0] PIO_STROBE_CYC = 12'h003;
  localparam logic [CNT_W-1:0] STOP_HOLD_CYC = 12'h002;

  // register addresses on the address lines
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
  localparam logic [2:0] ADDR_CMD = 3'h7;
  localparam logic [2:0] ADDR_DEVCTL = 3'h6;

  // field positions
  localparam int BIT_DEV = 4;
  localparam int BIT_SRST = 2;
  localparam int BIT_NIEN = 1;
  localparam logic DEV_NUM = 1'h0;

  // receive buffer level above which the device pauses data-out words, leaving slots for words in flight
  localparam logic [LVL_W-1:0] OUT_READY_LEVEL = LVL_W'(FIFO_DEPTH - 3);

  typedef enum logic [1:0] {DEV_IDLE, DEV_REQ, DEV_BURST, DEV_END} devState_t;

  typedef enum logic [3:0] {
    H_RESET, H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_ACK, H_OUT, H_IN, H_END
  } hostState_t;

endpackage

/* File: design/ata_if.sv */
// wires of the parallel disk port between host end and device end
// the shared data bus level is resolved here from the two enables
`timescale 1ns/1ps
interface ata_if
  import ata_pkg::*;
();
  logic ataResetN;
  logic cs0N;
  logic cs1N;
  logic [2:0] da;
  logic diowN;
  logic diorN;
  logic iordy;
  logic dmackN;
  logic dmarq;
  logic intrq;
  logic intrqOe;
  logic [DATA_W-1:0] hostDd;
  logic hostDdOe;
  logic [DATA_W-1:0] devDd;
  logic devDdOe;
  logic [DATA_W-1:0] dd;

  // undriven bus floats high through the pull-ups
  assign dd = devDdOe ? devDd : (hostDdOe ? hostDd : 16'hFFFF);

  modport host (
    output ataResetN, cs0N, cs1N, da, diowN, diorN, dmackN, hostDd, hostDdOe,
    input iordy, dmarq, intrq, intrqOe, dd
  );

  modport dev (
    input ataResetN, cs0N, cs1N, da, diowN, diorN, dmackN, dd,
    output iordy, dmarq, intrq, intrqOe, devDd, devDdOe
  );
endinterface

/* File: design/fifo_buf.sv */
// word buffer with valid and ready on both sides
// DEPTH must be a power of two
`timescale 1ns/1ps
module fifo_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic notFull;
    logic notEmpty;
  } fifoSt_t;

  fifoSt_t s_q;
  fifoSt_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  always_comb
  begin
    s_d = s_q;
    push = inValid & s_q.notFull;
    pop = outReady & s_q.notEmpty;
    if (push)
      s_d.wrPtr = s_q.wrPtr + 1'b1;
    if (pop)
      s_d.rdPtr = s_q.rdPtr + 1'b1;
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    s_d.notFull = s_d.count != (AW+1)'(DEPTH);
    s_d.notEmpty = s_d.count != '0;
    if (!resetn)
    begin
      s_d = '0;
      s_d.notFull = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
    if (push)
      mem[s_q.wrPtr] <= inData;
  end

  assign inReady = s_q.notFull;
  assign outValid = s_q.notEmpty;
  assign outData = mem[s_q.rdPtr];
  assign level = s_q.count;
endmodule

/* File: design/ata_dev_end.sv */
// device end of the parallel disk port: register strobes, interrupt line,
// ultra dma bursts in both directions, received words through a buffer
// assumes the host end runs on the same mclk, so link pins need no sync
`timescale 1ns/1ps
module ata_dev_end
  import ata_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link to the host
  ata_if.dev link,
  // words received from the host
  output logic [DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  // words sent to the host
  input wire logic [DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txTaken,
  // command, status and interrupt
  output logic [7:0] cmdCode,
  output logic cmdStrobe,
  output logic softReset,
  input wire logic [7:0] statusIn,
  input wire logic intEvent,
  input wire logic sectorDone,
  // dma request
  input wire logic dmaReq,
  input wire logic dmaDirIn
);
  typedef struct packed {
    devState_t st;
    logic dirIn;
    logic dmarq;
    logic ioLine;
    logic [DATA_W-1:0] ddOut;
    logic ddOe;
    logic intrq;
    logic intrqOe;
    logic nien;
    logic devSel;
    logic prevDiow;
    logic prevDior;
    logic pending;
    logic [7:0] cmdCode;
    logic cmdStrobe;
    logic softReset;
    logic txTaken;
  } devSt_t;

  devSt_t s_q;
  devSt_t s_d;
  logic push;
  logic [LVL_W-1:0] level;
  logic wrEdge;
  logic rdEdge;
  logic selected;
  logic cmdSel;
  logic ctlSel;
  logic stopSeen;

  fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .mclk(mclk),
    .resetn(resetn),
    .inData(link.dd),
    .inValid(push),
    .inReady(),
    .outData(rxData),
    .outValid(rxValid),
    .outReady(rxReady),
    .level(level)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.cmdStrobe = 1'b0;
    s_d.softReset = 1'b0;
    s_d.txTaken = 1'b0;
    s_d.prevDiow = link.diowN;
    s_d.prevDior = link.diorN;
    push = 1'b0;
    wrEdge = s_q.prevDiow & ~link.diowN;
    rdEdge = s_q.prevDior & ~link.diorN;
    selected = s_q.devSel == DEV_NUM;
    cmdSel = ~link.cs0N & link.cs1N;
    ctlSel = link.cs0N & ~link.cs1N;
    stopSeen = link.diowN;
    case (s_q.st)
      DEV_IDLE:
      begin
        s_d.ioLine = level != LVL_W'(FIFO_DEPTH);
        if (wrEdge)
        begin
          if (cmdSel && link.da == ADDR_DEVHEAD)
            s_d.devSel = link.dd[BIT_DEV];
          else if (selected && cmdSel && link.da == ADDR_DATA)
            push = 1'b1;
          else if (selected && cmdSel && link.da == ADDR_CMD)
          begin
            s_d.cmdCode = link.dd[7:0];
            s_d.cmdStrobe = 1'b1;
            s_d.intrq = 1'b0;
          end
          else if (selected && ctlSel && link.da == ADDR_DEVCTL)
          begin
            s_d.nien = link.dd[BIT_NIEN];
            if (link.dd[BIT_SRST])
            begin
              s_d.softReset = 1'b1;
              s_d.intrq = 1'b0;
            end
          end
        end
        // drive bus only while read strobe low
        if (rdEdge && selected && (cmdSel ^ ctlSel))
        begin
          s_d.ddOe = 1'b1;
          s_d.ddOut = '0;
          if (cmdSel && link.da == ADDR_DATA)
          begin
            s_d.ddOut = txData;
            s_d.txTaken = txValid;
          end
          else if (link.da == ADDR_CMD || (ctlSel && link.da == ADDR_DEVCTL))
            s_d.ddOut = {8'h00, statusIn};
          if (cmdSel && link.da == ADDR_CMD)
            s_d.intrq = 1'b0;
        end
        if (link.diorN)
          s_d.ddOe = 1'b0;
        if (dmaReq && selected && link.diorN && link.diowN)
        begin
          s_d.st = DEV_REQ;
          s_d.dmarq = 1'b1;
          s_d.dirIn = dmaDirIn;
        end
      end
      DEV_REQ:
      begin
        // line parked high in both directions, so the host sees no strobe
        // edge before the first data-in word is on the bus
        s_d.ioLine = 1'b1;
        if (!link.dmackN)
        begin
          s_d.st = DEV_BURST;
          s_d.pending = 1'b0;
        end
      end
      DEV_BURST:
      begin
        if (s_q.dirIn)
        begin
          s_d.ddOe = 1'b1;
          if (s_q.pending)
          begin
            s_d.ioLine = ~s_q.ioLine;
            s_d.pending = 1'b0;
          end
          else if (txValid && !link.diorN && !stopSeen)
          begin
            s_d.ddOut = txData;
            s_d.txTaken = 1'b1;
            s_d.pending = 1'b1;
          end
        end
        else
        begin
          s_d.ioLine = level > OUT_READY_LEVEL;
          push = link.diorN != s_q.prevDior;
        end
        if (stopSeen && !s_d.pending)
        begin
          s_d.st = DEV_END;
          s_d.dmarq = 1'b0;
        end
      end
      DEV_END:
      begin
        s_d.ddOe = 1'b0;
        s_d.ioLine = 1'b1;
        if (link.dmackN)
          s_d.st = DEV_IDLE;
      end
      default:
      begin
        s_d.st = DEV_IDLE;
      end
    endcase
    if (sectorDone)
      s_d.intrq = 1'b0;
    if (intEvent)
      s_d.intrq = 1'b1;
    s_d.intrqOe = (s_d.devSel == DEV_NUM) & ~s_d.nien;
    // link reset clears device state like local reset; the receive buffer clears on resetn only
    if (!resetn || !link.ataResetN)
    begin
      s_d = '0;
      s_d.prevDiow = 1'b1;
      s_d.prevDior = 1'b1;
      s_d.ioLine = 1'b1;
      s_d.intrqOe = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign link.iordy = s_q.ioLine;
  assign link.dmarq = s_q.dmarq;
  assign link.intrq = s_q.intrq;
  assign link.intrqOe = s_q.intrqOe;
  assign link.devDd = s_q.ddOut;
  assign link.devDdOe = s_q.ddOe;
  assign cmdCode = s_q.cmdCode;
  assign cmdStrobe = s_q.cmdStrobe;
  assign softReset = s_q.softReset;
  assign txTaken = s_q.txTaken;
endmodule

/* File: design/ata_host_end.sv */
// host end of the parallel disk port: power-on link reset, register
// reads and writes with strobes, ultra dma bursts in both directions
// assumes the device end runs on the same mclk, so link pins need no sync
//
// Behaviour
// - low reset line resets; hold 25 us
// - one shared 16-bit bus, one driver
// - write strobe writes; device captures value
// - write strobe negated before a burst
// - stop stays negated until words move; host raises stop on udmaStop even before the first word
// - stop mid-burst makes device end burst
// - host drives its ready during data-in
// - host strobes each data-out word
// - device drives its ready during data-out
// - device strobes each data-in word
// - address bits plus chip select pick register
// - interrupt cleared by reset, command, status, sector
// - interrupt released when unselected or disabled
// - read strobe reads; pausing strobe pauses out
`timescale 1ns/1ps
module ata_host_end
  import ata_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link to the device
  ata_if.host link,
  // register access requests
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqCtl,
  input wire logic [2:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  // register read answer
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  // burst control
  input wire logic udmaEn,
  input wire logic udmaDirIn,
  input wire logic udmaStop,
  // words sent in data-out bursts
  input wire logic [DATA_W-1:0] outData,
  input wire logic outValid,
  output logic outTaken,
  // words received in data-in bursts
  output logic [DATA_W-1:0] inData,
  output logic inValid,
  input wire logic inReady
);
  typedef struct packed {
    hostState_t st;
    logic [CNT_W-1:0] cnt;
    logic ataResetN;
    logic cs0N;
    logic cs1N;
    logic [2:0] da;
    logic diowLine;
    logic diorLine;
    logic dmackN;
    logic [DATA_W-1:0] ddOut;
    logic ddOe;
    logic isWrite;
    logic dirIn;
    logic pending;
    logic prevIo;
    logic reqReady;
    logic rdValid;
    logic [DATA_W-1:0] rdData;
    logic outTaken;
    logic [DATA_W-1:0] inData;
    logic inValid;
  } hostSt_t;

  hostSt_t s_q;
  hostSt_t s_d;
  logic ioToggled;

  always_comb
  begin
    s_d = s_q;
    s_d.rdValid = 1'b0;
    s_d.outTaken = 1'b0;
    s_d.inValid = 1'b0;
    s_d.prevIo = link.iordy;
    ioToggled = link.iordy != s_q.prevIo;
    case (s_q.st)
      H_RESET:
      begin
        if (s_q.cnt == RESET_HOLD_CYC - 1'b1)
        begin
          s_d.ataResetN = 1'b1;
          s_d.reqReady = 1'b1;
          s_d.st = H_IDLE;
        end
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      H_IDLE:
      begin
        if (reqValid && s_q.reqReady)
        begin
          s_d.cs0N = reqCtl;
          s_d.cs1N = ~reqCtl;
          s_d.da = reqAddr;
          s_d.isWrite = reqWrite;
          s_d.ddOut = reqData;
          s_d.ddOe = reqWrite;
          s_d.reqReady = 1'b0;
          s_d.st = H_SETUP;
        end
        else if (link.dmarq && udmaEn)
        begin
          s_d.dmackN = 1'b0;
          s_d.reqReady = 1'b0;
          s_d.dirIn = udmaDirIn;
          s_d.st = H_ACK;
        end
      end
      H_SETUP:
      begin
        // wait on the ready line so a full receive buffer drops no word
        if (link.iordy)
        begin
          s_d.diowLine = ~s_q.isWrite;
          s_d.diorLine = s_q.isWrite;
          s_d.cnt = PIO_STROBE_CYC - 1'b1;
          s_d.st = H_STROBE;
        end
      end
      H_STROBE:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.diowLine = 1'b1;
          s_d.diorLine = 1'b1;
          if (!s_q.isWrite)
          begin
            s_d.rdData = link.dd;
            s_d.rdValid = 1'b1;
          end
          s_d.st = H_HOLD;
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      H_HOLD:
      begin
        s_d.cs0N = 1'b1;
        s_d.cs1N = 1'b1;
        s_d.ddOe = 1'b0;
        s_d.reqReady = 1'b1;
        s_d.st = H_IDLE;
      end
      H_ACK:
      begin
        s_d.diowLine = 1'b0;
        s_d.diorLine = s_q.dirIn ? ~inReady : 1'b1;
        s_d.pending = 1'b0;
        s_d.st = s_q.dirIn ? H_IN : H_OUT;
      end
      H_OUT:
      begin
        if (s_q.pending)
        begin
          s_d.diorLine = ~s_q.diorLine;
          s_d.pending = 1'b0;
        end
        else if (udmaStop)
        begin
          s_d.st = H_END;
          s_d.cnt = STOP_HOLD_CYC;
        end
        else if (outValid && !link.iordy)
        begin
          s_d.ddOut = outData;
          s_d.ddOe = 1'b1;
          s_d.outTaken = 1'b1;
          s_d.pending = 1'b1;
        end
      end
      H_IN:
      begin
        s_d.diorLine = ~inReady;
        if (udmaStop)
        begin
          s_d.st = H_END;
          s_d.cnt = STOP_HOLD_CYC;
        end
      end
      H_END:
      begin
        s_d.diowLine = 1'b1;
        s_d.ddOe = 1'b0;
        if (s_q.cnt == '0)
        begin
          s_d.dmackN = 1'b1;
          s_d.diorLine = 1'b1;
          s_d.reqReady = 1'b1;
          s_d.st = H_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      end
      default:
      begin
        s_d.st = H_IDLE;
      end
    endcase
    // device strobe edge carries a word
    if ((s_q.st == H_IN || s_q.st == H_END) && s_q.dirIn && ioToggled)
    begin
      s_d.inData = link.dd;
      s_d.inValid = 1'b1;
    end
    if (!resetn)
    begin
      s_d = '0;
      s_d.st = H_RESET;
      s_d.cs0N = 1'b1;
      s_d.cs1N = 1'b1;
      s_d.diowLine = 1'b1;
      s_d.diorLine = 1'b1;
      s_d.dmackN = 1'b1;
      s_d.prevIo = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign link.ataResetN = s_q.ataResetN;
  assign link.cs0N = s_q.cs0N;
  assign link.cs1N = s_q.cs1N;
  assign link.da = s_q.da;
  assign link.diowN = s_q.diowLine;
  assign link.diorN = s_q.diorLine;
  assign link.dmackN = s_q.dmackN;
  assign link.hostDd = s_q.ddOut;
  assign link.hostDdOe = s_q.ddOe;
  assign reqReady = s_q.reqReady;
  assign rdValid = s_q.rdValid;
  assign rdData = s_q.rdData;
  assign outTaken = s_q.outTaken;
  assign inData = s_q.inData;
  assign inValid = s_q.inValid;
endmodule

/* File: sim/ata_link_checker.sv */
// assertions on the link between the host end and the device end
// assumes one mclk and a synchronous active-low resetn for both ends
`timescale 1ns/1ps
module ata_link_checker
  import ata_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link signals
  input wire logic ataResetN,
  input wire logic cs0N,
  input wire logic cs1N,
  input wire logic [2:0] da,
  input wire logic diowN,
  input wire logic diorN,
  input wire logic iordy,
  input wire logic dmackN,
  input wire logic dmarq,
  input wire logic intrq,
  input wire logic hostDdOe,
  input wire logic devDdOe,
  input wire logic [DATA_W-1:0] dd
);
  logic [CNT_W-1:0] lowCnt_q;
  logic [CNT_W-1:0] lowCnt_d;

  // saturating, so a stuck reset line cannot wrap to a short count
  always_comb
  begin
    lowCnt_d = (&lowCnt_q) ? lowCnt_q : lowCnt_q + 12'h001;
    if (ataResetN)
      lowCnt_d = '0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      lowCnt_q <= '0;
    else
      lowCnt_q <= lowCnt_d;
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence burstStart;
    $fell(dmackN);
  endsequence

  sequence stopRaised;
    $rose(diowN) && !dmackN;
  endsequence

  chk_bus_one_driver:
  assert property (!(hostDdOe && devDdOe)) else $error("both ends drive the bus");
  chk_reset_hold_time:
  assert property ($rose(ataResetN) |-> lowCnt_q >= RESET_HOLD_CYC - 12'h001)
    else $error("link reset too short");
  chk_reset_clears_dev:
  assert property (!ataResetN |=> !dmarq && !devDdOe && !intrq)
    else $error("device active in link reset");
  chk_write_strobe_width:
  assert property ($fell(diowN) && dmackN |->
    (!diowN && $stable(da) && $stable(dd))[*3] ##1 diowN)
    else $error("write strobe shape wrong");
  chk_strobe_has_select:
  assert property ((!diowN || !diorN) && dmackN |-> cs0N != cs1N)
    else $error("strobe without one chip select");
  chk_ack_after_request:
  assert property (burstStart |-> dmarq && diowN) else $error("bad burst acknowledge");
  chk_stop_negated_first:
  assert property (burstStart |=> !diowN) else $error("stop at burst start");
  chk_stop_ends_burst:
  assert property (stopRaised |-> ##[1:40] (!dmarq && !devDdOe && dmackN))
    else $error("burst not ended after stop");
  chk_in_strobe_data:
  assert property (!dmackN && devDdOe && $past(devDdOe) && $changed(iordy) |-> $stable(dd))
    else $error("data moved on device strobe");
  chk_out_strobe_data:
  assert property (!dmackN && hostDdOe && $past(hostDdOe) && $changed(diorN) |-> $stable(dd))
    else $error("data moved on host strobe");
  chk_cmd_clears_irq:
  assert property ($fell(diowN) && dmackN && !cs0N && da == ADDR_CMD |-> ##[1:3] !intrq)
    else $error("command write left interrupt set");
endmodule

/* File: sim/ata_host_port_signal_layer_test.sv */
// bench: host end and device end joined by the link, both user sides driven
// assumes the design runs on one 100 MHz mclk with synchronous resetn
`timescale 1ns/1ps
module ata_host_port_signal_layer_test
  import ata_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqCtl = 1'b0;
  logic [2:0] reqAddr = 3'h0;
  logic [15:0] reqData = 16'h0000;
  logic udmaEn = 1'b0;
  logic dirIn = 1'b0;
  logic udmaStop = 1'b0;
  logic inReady = 1'b1;
  logic rxReady = 1'b1;
  logic intEvent = 1'b0;
  logic sectorDone = 1'b0;
  logic dmaReq = 1'b0;
  logic outLive = 1'b0;
  logic txLive = 1'b0;
  logic [7:0] statusIn = 8'h5A;
  logic [15:0] outCnt = 16'h0000;
  logic [15:0] txCnt = 16'h0000;
  logic [15:0] rxCnt = 16'h0000;
  logic [15:0] inCnt = 16'h0000;
  logic reqReady, rdValid, outTaken, inValid, rxValid, txTaken, cmdStrobe, softReset;
  logic outValid, txValid;
  logic [15:0] rdData, inData, rxData, txData, outData;
  logic [7:0] cmdCode;
  int errors = 0;
  int checkCount = 0;
  int cmdSeen = 0;
  int srstSeen = 0;
  int rdSeen = 0;

  // word streams are counters so order and loss show at the far end
  assign outData = 16'hA001 + outCnt;
  assign outValid = outLive && outCnt < 16'h000C;
  assign txData = 16'h5000 + txCnt;
  assign txValid = txLive && txCnt < 16'h000B;

  always #5 mclk = ~mclk;

  ata_if i_ata_if ();
  ata_host_end i_ata_host_end (
    .mclk(mclk), .resetn(resetn), .link(i_ata_if), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqCtl(reqCtl), .reqAddr(reqAddr),
    .reqData(reqData), .rdValid(rdValid), .rdData(rdData), .udmaEn(udmaEn),
    .udmaDirIn(dirIn), .udmaStop(udmaStop), .outData(outData), .outValid(outValid),
    .outTaken(outTaken), .inData(inData), .inValid(inValid), .inReady(inReady)
  );
  ata_dev_end i_ata_dev_end (
    .mclk(mclk), .resetn(resetn), .link(i_ata_if), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txTaken(txTaken),
    .cmdCode(cmdCode), .cmdStrobe(cmdStrobe), .softReset(softReset),
    .statusIn(statusIn), .intEvent(intEvent), .sectorDone(sectorDone),
    .dmaReq(dmaReq), .dmaDirIn(dirIn)
  );
  ata_link_checker i_ata_link_checker (
    .mclk(mclk), .resetn(resetn), .ataResetN(i_ata_if.ataResetN), .cs0N(i_ata_if.cs0N),
    .cs1N(i_ata_if.cs1N), .da(i_ata_if.da), .diowN(i_ata_if.diowN),
    .diorN(i_ata_if.diorN), .iordy(i_ata_if.iordy), .dmackN(i_ata_if.dmackN),
    .dmarq(i_ata_if.dmarq), .intrq(i_ata_if.intrq), .hostDdOe(i_ata_if.hostDdOe),
    .devDdOe(i_ata_if.devDdOe), .dd(i_ata_if.dd)
  );

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checkWord({15'h0000, got}, {15'h0000, exp});
  endtask

  always @(posedge mclk)
  begin
    if (outTaken)
      outCnt <= outCnt + 16'h0001;
    if (txTaken)
      txCnt <= txCnt + 16'h0001;
    if (cmdStrobe)
      cmdSeen++;
    if (softReset)
      srstSeen++;
    if (rdValid)
      rdSeen++;
    if (rxValid && rxReady)
    begin
      checkWord(rxData, 16'hA000 + rxCnt);
      rxCnt <= rxCnt + 16'h0001;
    end
    if (inValid)
    begin
      checkWord(inData, 16'h5001 + inCnt);
      inCnt <= inCnt + 16'h0001;
    end
  end

  task automatic regOp(input logic wr, input logic ctl, input logic [2:0] addr,
    input logic [15:0] data);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqCtl <= ctl;
    reqAddr <= addr;
    reqData <= data;
    do
      @(posedge mclk);
    while (!reqReady);
    reqValid <= 1'b0;
    @(posedge mclk);
    while (!reqReady)
      @(posedge mclk);
  endtask

  task automatic pulseIn(input logic sector);
    @(posedge mclk);
    intEvent <= !sector;
    sectorDone <= sector;
    @(posedge mclk);
    intEvent <= 1'b0;
    sectorDone <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic endBurst();
    udmaStop <= 1'b1;
    dmaReq <= 1'b0;
    @(posedge mclk);
    while (!i_ata_if.dmackN)
      @(posedge mclk);
    udmaStop <= 1'b0;
    udmaEn <= 1'b0;
    checkBit(i_ata_if.dmarq, 1'b0);
  endtask

  task automatic testReset();
    int n;
    n = 0;
    while (!reqReady)
    begin
      @(posedge mclk);
      n++;
    end
    checkBit(1'(n >= RESET_HOLD_US * 1000 / CLK_PERIOD_NS), 1'b1);
  endtask

  task automatic testRegisters();
    pulseIn(1'b0);
    checkBit(i_ata_if.intrq, 1'b1);
    regOp(1'b1, 1'b0, ADDR_CMD, 16'h00C8);
    checkWord({8'h00, cmdCode}, 16'h00C8);
    checkBit(1'(cmdSeen == 1), 1'b1);
    checkBit(i_ata_if.intrq, 1'b0);
    pulseIn(1'b0);
    regOp(1'b0, 1'b1, ADDR_DEVCTL, 16'h0000);
    checkWord({8'h00, rdData[7:0]}, 16'h005A);
    checkBit(i_ata_if.intrq, 1'b1);
    regOp(1'b0, 1'b0, ADDR_CMD, 16'h0000);
    checkWord({8'h00, rdData[7:0]}, 16'h005A);
    checkBit(i_ata_if.intrq, 1'b0);
    pulseIn(1'b0);
    pulseIn(1'b1);
    checkBit(i_ata_if.intrq, 1'b0);
    pulseIn(1'b0);
    regOp(1'b1, 1'b1, ADDR_DEVCTL, 16'h0004);
    checkBit(1'(srstSeen == 1), 1'b1);
    checkBit(i_ata_if.intrq, 1'b0);
    regOp(1'b1, 1'b1, ADDR_DEVCTL, 16'h0002);
    checkBit(i_ata_if.intrqOe, 1'b0);
    regOp(1'b1, 1'b1, ADDR_DEVCTL, 16'h0000);
    regOp(1'b1, 1'b0, ADDR_DEVHEAD, 16'h0010);
    checkBit(i_ata_if.intrqOe, 1'b0);
    // unselected device ignores a command and leaves the bus to the pull-ups
    regOp(1'b1, 1'b0, ADDR_CMD, 16'h00EC);
    checkBit(1'(cmdSeen == 1), 1'b1);
    regOp(1'b0, 1'b0, ADDR_CMD, 16'h0000);
    checkWord(rdData, 16'hFFFF);
    regOp(1'b1, 1'b0, ADDR_DEVHEAD, 16'h0000);
    checkBit(i_ata_if.intrqOe, 1'b1);
  endtask

  task automatic testPio();
    txLive <= 1'b1;
    regOp(1'b0, 1'b0, ADDR_DATA, 16'h0000);
    txLive <= 1'b0;
    checkWord(rdData, 16'h5000);
    checkWord(txCnt, 16'h0001);
    checkBit(1'(rdSeen == 4), 1'b1);
    regOp(1'b1, 1'b0, ADDR_DATA, 16'hA000);
    checkWord(rxCnt, 16'h0001);
  endtask

  task automatic testBurstOut();
    rxReady <= 1'b0;
    dirIn <= 1'b0;
    outLive <= 1'b1;
    dmaReq <= 1'b1;
    udmaEn <= 1'b1;
    while (outCnt < 16'h0006)
      @(posedge mclk);
    // stalled drain: the device must hold the host off, not drop words
    repeat (20) @(posedge mclk);
    checkBit(i_ata_if.iordy, 1'b1);
    checkWord(rxCnt, 16'h0001);
    rxReady <= 1'b1;
    while (rxCnt < 16'h000D)
      @(posedge mclk);
    endBurst();
    outLive <= 1'b0;
  endtask

  task automatic testBurstIn();
    logic [15:0] seen;
    dirIn <= 1'b1;
    txLive <= 1'b1;
    dmaReq <= 1'b1;
    udmaEn <= 1'b1;
    while (inCnt < 16'h0004)
      @(posedge mclk);
    inReady <= 1'b0;
    seen = inCnt;
    repeat (20) @(posedge mclk);
    checkBit(1'(inCnt - seen <= 16'h0002), 1'b1);
    inReady <= 1'b1;
    while (inCnt < 16'h000A)
      @(posedge mclk);
    endBurst();
    txLive <= 1'b0;
  endtask

  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (12000) @(posedge mclk);
    errors++;
    printVerdict();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    testReset();
    testRegisters();
    testPio();
    testBurstOut();
    testBurstIn();
    printVerdict();
  end
endmodule
